// file: logic/cem_pkg.sv
package cem_pkg;
  // Register indices on the plain port
  localparam logic [2:0] CEM_MODE_ADDR = 3'h0;
  localparam logic [2:0] CEM_IRQ_STAT_ADDR = 3'h1;
  localparam logic [2:0] CEM_IRQ_MASK_ADDR = 3'h2;
  localparam logic [2:0] CEM_LOCK_ADDR = 3'h3;
  // Mode register field positions
  localparam int CEM_SETUP_BIT = 7;
  localparam int CEM_IN_BIT = 6;
  localparam int CEM_OUT_BIT = 5;
  localparam int CEM_ACK_BIT = 4;
  localparam logic [7:0] CEM_MODE_RESET = 8'h00;
  localparam logic [3:0] CEM_RESP_RESET = 4'h0;
  localparam logic [3:0] CEM_IRQ_RESET = 4'h0;
endpackage

// file: logic/cem_top.sv
`timescale 1ns/10ps
// Behaviour
// - An engine write locks the mode or count register until the processor reads it.
// - An accepted processor write to the mode register clears the four flag bits, except one whose event or hold falls in the same cycle.
// - The setup flag in bit 7 is set when a valid setup packet arrives.
// - The setup flag is held high from setup data until a control write data stage ends.
// - While the setup flag is one, processor writes to the endpoint buffer are rejected.
// - The flags clear on any unlocked processor write to the mode register, save one set by an event or by SETUP_HOLD in that cycle.
module cem_top
  import cem_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Register port
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Protocol engine events, one-cycle pulses except ENG_MODE_DATA, the data for ENG_MODE_WR, and SETUP_HOLD, which is a level held for as long as the hold lasts
  input wire logic ENG_MODE_WR,
  input wire logic [3:0] ENG_MODE_DATA,
  input wire logic ENG_CNT_WR,
  input wire logic CNT_RD,
  input wire logic SETUP_OK,
  input wire logic SETUP_HOLD,
  input wire logic OUT_DONE,
  input wire logic IN_ACKED,
  input wire logic XFER_ACKED,
  // Endpoint buffer write request from processor
  input wire logic BUF_WR_REQ,
  output logic BUF_WR_EN,
  // Status out
  output logic [3:0] RESP_MODE,
  output logic MODE_LOCKED,
  output logic CNT_LOCKED,
  output logic IRQ
);
  // Reset release: asserts at once, lets go two edges later
  logic rs1_q, rst_n;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rs1_q <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rs1_q <= 1'h1;
      rst_n <= rs1_q;
    end
  end

  // Flag positions inside the upper nibble
  localparam int SETUP_IDX = CEM_SETUP_BIT - CEM_ACK_BIT;
  localparam int IN_IDX = CEM_IN_BIT - CEM_ACK_BIT;
  localparam int OUT_IDX = CEM_OUT_BIT - CEM_ACK_BIT;
  localparam int ACK_IDX = CEM_ACK_BIT - CEM_ACK_BIT;

  // State and next values
  logic [3:0] flags_q, flags_d, resp_q, resp_d;
  logic [3:0] stat_q, stat_d, mask_q, mask_d;
  logic mlock_q, mlock_d, clock_q, clock_d;
  logic bufen_d, irq_d;
  logic [7:0] rdata_d;

  // Decoded strobes and events
  logic mode_wr, mode_rd, stat_wr, mask_wr, mode_wr_ok;
  logic [3:0] ev, flag_next, stat_next;

  always_comb begin
    mode_wr = WR && (ADDR == CEM_MODE_ADDR);
    mode_rd = RD && (ADDR == CEM_MODE_ADDR);
    stat_wr = WR && (ADDR == CEM_IRQ_STAT_ADDR);
    mask_wr = WR && (ADDR == CEM_IRQ_MASK_ADDR);
    // A locked register ignores the write altogether
    mode_wr_ok = mode_wr && !mlock_q;
    ev[SETUP_IDX] = SETUP_OK;
    ev[IN_IDX] = IN_ACKED;
    ev[OUT_IDX] = OUT_DONE;
    ev[ACK_IDX] = XFER_ACKED;
  end

  // Sticky bits: an event in the clearing cycle wins
  for (genvar gi = 0; gi < 4; gi = gi + 1) begin : g_sticky
    assign flag_next[gi] = ev[gi] | (flags_q[gi] & !mode_wr_ok);
    assign stat_next[gi] = ev[gi] | (stat_q[gi] & !(stat_wr && WDATA[gi]));
  end

  // Write interlock for the mode and count registers
  always_comb begin
    mlock_d = mlock_q;
    clock_d = clock_q;
    // A read unlocks; an engine write in the same cycle locks again
    if (mode_rd) mlock_d = 1'h0;
    if (ENG_MODE_WR) mlock_d = 1'h1;
    if (CNT_RD) clock_d = 1'h0;
    if (ENG_CNT_WR) clock_d = 1'h1;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mlock_q <= 1'h0;
      clock_q <= 1'h0;
    end else begin
      mlock_q <= mlock_d;
      clock_q <= clock_d;
    end
  end

  // Status flags and response mode field
  always_comb begin
    flags_d = flag_next;
    // Cannot be cleared while setup data or a control write is under way
    if (SETUP_HOLD) flags_d[SETUP_IDX] = 1'h1;
    resp_d = resp_q;
    if (mode_wr_ok) resp_d = WDATA[3:0];
    // Engine data wins over a processor write in the same cycle
    if (ENG_MODE_WR) resp_d = ENG_MODE_DATA;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= CEM_MODE_RESET[7:4];
      resp_q <= CEM_RESP_RESET;
    end else begin
      flags_q <= flags_d;
      resp_q <= resp_d;
    end
  end

  // Interrupt status, mask and level output
  always_comb begin
    stat_d = stat_next;
    mask_d = mask_q;
    if (mask_wr) mask_d = WDATA[3:0];
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= CEM_IRQ_RESET;
      mask_q <= CEM_IRQ_RESET;
      IRQ <= 1'h0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      IRQ <= irq_d;
    end
  end

  // Read data and buffer write grant
  always_comb begin
    // Grant only when the setup flag is clear now and next cycle
    bufen_d = BUF_WR_REQ && !flags_d[SETUP_IDX] && !flags_q[SETUP_IDX];
    rdata_d = 8'h00;
    if (RD) begin
      case (ADDR)
        CEM_MODE_ADDR: rdata_d = {flags_q, resp_q};
        CEM_IRQ_STAT_ADDR: rdata_d = {4'h0, stat_q};
        CEM_IRQ_MASK_ADDR: rdata_d = {4'h0, mask_q};
        CEM_LOCK_ADDR: rdata_d = {6'h00, clock_q, mlock_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 8'h00;
      BUF_WR_EN <= 1'h0;
    end else begin
      RDATA <= rdata_d;
      BUF_WR_EN <= bufen_d;
    end
  end

  assign RESP_MODE = resp_q;
  assign MODE_LOCKED = mlock_q;
  assign CNT_LOCKED = clock_q;

  locked_write_a: assert property (@(posedge CLK) disable iff (!rst_n)
    WR && ADDR == CEM_MODE_ADDR && mlock_q && !ENG_MODE_WR |=> resp_q == $past(resp_q))
    else $error("locked mode write took effect");
  lock_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
    ENG_MODE_WR |=> mlock_q)
    else $error("engine write did not lock");
  cnt_lock_a: assert property (@(posedge CLK) disable iff (!rst_n)
    ENG_CNT_WR |=> CNT_LOCKED)
    else $error("engine count write did not lock");
  read_unlock_a: assert property (@(posedge CLK) disable iff (!rst_n)
    mode_rd && !ENG_MODE_WR |=> !mlock_q)
    else $error("mode read did not unlock");
  locked_flags_a: assert property (@(posedge CLK) disable iff (!rst_n)
    mode_wr && mlock_q && ev == 4'h0 && !SETUP_HOLD |=> flags_q == $past(flags_q))
    else $error("locked write changed flags");
  flag_clear_a: assert property (@(posedge CLK) disable iff (!rst_n)
    mode_wr_ok && ev == 4'h0 && !SETUP_HOLD |=> flags_q == 4'h0)
    else $error("write did not clear flags");
  setup_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
    SETUP_OK |=> flags_q[3])
    else $error("setup flag not set");
  setup_hold_a: assert property (@(posedge CLK) disable iff (!rst_n)
    SETUP_HOLD |=> flags_q[3])
    else $error("setup flag cleared while held");
  buf_block_a: assert property (@(posedge CLK) disable iff (!rst_n)
    flags_q[3] |=> !BUF_WR_EN)
    else $error("buffer write during setup");
  buf_grant_a: assert property (@(posedge CLK) disable iff (!rst_n)
    BUF_WR_REQ && !flags_q[SETUP_IDX] && !SETUP_OK && !SETUP_HOLD |=> BUF_WR_EN)
    else $error("buffer write refused without setup");
  unlock_clear_a: assert property (@(posedge CLK) disable iff (!rst_n)
    mode_wr_ok && !OUT_DONE |=> !flags_q[1])
    else $error("OUT flag survived write");
  out_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
    OUT_DONE |=> flags_q[1])
    else $error("OUT flag not set");
  ack_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
    XFER_ACKED |=> flags_q[0])
    else $error("ack flag not set");
  in_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
    IN_ACKED |=> flags_q[2])
    else $error("IN flag not set");
  mode_wr_a: assert property (@(posedge CLK) disable iff (!rst_n)
    mode_wr_ok && !ENG_MODE_WR |=> RESP_MODE == $past(WDATA[3:0]))
    else $error("mode field not written");
  mode_read_a: assert property (@(posedge CLK) disable iff (!rst_n)
    mode_rd |=> RDATA == {$past(flags_q), $past(resp_q)})
    else $error("mode read returned wrong data");
  read_unlock_c: cover property (@(posedge CLK) disable iff (!rst_n)
    ENG_MODE_WR ##1 RD && ADDR == CEM_MODE_ADDR ##1 mode_wr_ok);
  setup_block_c: cover property (@(posedge CLK) disable iff (!rst_n)
    SETUP_OK ##1 BUF_WR_REQ);
  setup_hold_c: cover property (@(posedge CLK) disable iff (!rst_n)
    SETUP_HOLD && mode_wr);
  cnt_unlock_c: cover property (@(posedge CLK) disable iff (!rst_n)
    CNT_LOCKED && CNT_RD);
  irq_c: cover property (@(posedge CLK) disable iff (!rst_n) IRQ);
endmodule

// file: dv/cem_host.sv
`timescale 1ns/10ps
module cem_host (
  // Clock
  input wire logic clk,
  // Outcome requests, {cnt,mode,setup,in,out,ack}
  input wire logic [5:0] req,
  // One-cycle outcome pulses to the engine side
  output logic [5:0] pulse
);
  always_ff @(posedge clk) begin
    pulse <= req & ~pulse;
  end
endmodule

// file: dv/tb.sv
`timescale 1ns/10ps
module tb;
  import cem_pkg::*;
  logic CLK = 1'h0, ARST_N = 1'h0, WR = 1'h0, RD = 1'h0, SETUP_HOLD = 1'h0;
  logic BUF_WR_REQ = 1'h0, CNT_RD = 1'h0;
  logic [2:0] ADDR = 3'h0;
  logic [7:0] WDATA = 8'h00, RDATA;
  logic [3:0] ENG_MODE_DATA = 4'h0, RESP_MODE;
  logic [5:0] req = 6'h00, pls;
  logic BUF_WR_EN, MODE_LOCKED, CNT_LOCKED, IRQ;
  int n_errors = 0, compares = 0;
  cem_host host_u (.clk(CLK), .req(req), .pulse(pls));
  cem_top dut_u (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .ENG_MODE_WR(pls[4]), .ENG_MODE_DATA(ENG_MODE_DATA), .ENG_CNT_WR(pls[5]),
    .CNT_RD(CNT_RD), .SETUP_OK(pls[3]), .SETUP_HOLD(SETUP_HOLD), .OUT_DONE(pls[1]),
    .IN_ACKED(pls[2]), .XFER_ACKED(pls[0]), .BUF_WR_REQ(BUF_WR_REQ), .BUF_WR_EN(BUF_WR_EN),
    .RESP_MODE(RESP_MODE), .MODE_LOCKED(MODE_LOCKED), .CNT_LOCKED(CNT_LOCKED), .IRQ(IRQ));
  initial begin
    forever #12.5 CLK = ~CLK;
  end
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      n_errors++;
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge CLK);
    WR <= 1'h1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'h0;
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] e);
    @(posedge CLK);
    RD <= 1'h1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'h0;
    #1 chk("rdata", RDATA, e);
  endtask
  task automatic ev(logic [5:0] b);
    @(posedge CLK);
    req <= b;
    @(posedge CLK);
    req <= 6'h00;
  endtask
  task automatic st;
    repeat (3) @(posedge CLK);
    #1;
  endtask
  task automatic t_flags;
    rd(CEM_MODE_ADDR, CEM_MODE_RESET);
    wr(CEM_MODE_ADDR, 8'hFF);
    rd(CEM_MODE_ADDR, 8'h0F);
    chk("resp", {4'h0, RESP_MODE}, 8'h0F);
    ev(6'h0F);
    st;
    rd(CEM_MODE_ADDR, 8'hFF);
    wr(CEM_MODE_ADDR, 8'hF5);
    rd(CEM_MODE_ADDR, 8'h05);
  endtask
  task automatic t_lock;
    @(posedge CLK);
    ENG_MODE_DATA <= 4'hA;
    ev(6'h10);
    st;
    chk("mlock", {7'h00, MODE_LOCKED}, 8'h01);
    wr(CEM_MODE_ADDR, 8'h03);
    st;
    chk("resp", {4'h0, RESP_MODE}, 8'h0A);
    rd(CEM_MODE_ADDR, 8'h0A);
    chk("mlock", {7'h00, MODE_LOCKED}, 8'h00);
    wr(CEM_MODE_ADDR, 8'h03);
    st;
    chk("resp", {4'h0, RESP_MODE}, 8'h03);
    ev(6'h20);
    st;
    chk("clock", {7'h00, CNT_LOCKED}, 8'h01);
    rd(CEM_LOCK_ADDR, 8'h02);
    @(posedge CLK) CNT_RD <= 1'h1;
    @(posedge CLK) CNT_RD <= 1'h0;
    st;
    chk("clock", {7'h00, CNT_LOCKED}, 8'h00);
  endtask
  task automatic t_setup;
    @(posedge CLK);
    SETUP_HOLD <= 1'h1;
    BUF_WR_REQ <= 1'h1;
    wr(CEM_MODE_ADDR, 8'h00);
    rd(CEM_MODE_ADDR, 8'h80);
    chk("bufen", {7'h00, BUF_WR_EN}, 8'h00);
    @(posedge CLK);
    SETUP_HOLD <= 1'h0;
    wr(CEM_MODE_ADDR, 8'h00);
    rd(CEM_MODE_ADDR, 8'h00);
    st;
    chk("bufen", {7'h00, BUF_WR_EN}, 8'h01);
    ev(6'h08);
    st;
    chk("bufen", {7'h00, BUF_WR_EN}, 8'h00);
    rd(CEM_MODE_ADDR, 8'h80);
    wr(CEM_MODE_ADDR, 8'h00);
    rd(CEM_MODE_ADDR, 8'h00);
    @(posedge CLK);
    BUF_WR_REQ <= 1'h0;
  endtask
  task automatic t_irq;
    wr(CEM_IRQ_STAT_ADDR, 8'h0F);
    wr(CEM_IRQ_MASK_ADDR, 8'h0F);
    st;
    chk("irq", {7'h00, IRQ}, 8'h00);
    ev(6'h01);
    st;
    chk("irq", {7'h00, IRQ}, 8'h01);
    rd(CEM_IRQ_STAT_ADDR, 8'h01);
    wr(CEM_IRQ_MASK_ADDR, 8'h00);
    st;
    chk("irq", {7'h00, IRQ}, 8'h00);
    wr(CEM_IRQ_STAT_ADDR, 8'h01);
    rd(CEM_IRQ_STAT_ADDR, 8'h00);
    rd(3'h7, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge CLK);
    ARST_N <= 1'h1;
    repeat (3) @(posedge CLK);
    t_flags();
    t_lock();
    t_setup();
    t_irq();
    tally_and_finish();
  end
endmodule
